// File: design/fswp_status_protect.sv
// Status word, write protection and suspend logic of a serial flash
`timescale 1ns/1ns
`include "fswp_map.svh"
// What this block does
// - Busy flag is one during program, erase or status write, else zero.
// - Latch shown in status; while clear, status write, program, erase refused.
// - Five protect size bits persist and block program and erase in their range.
// - Protect size bits change only outside hardware protected mode.
// - Chip erase only with low size bits 000 and invert 0, or 111 and invert 1.
// - Quad enable zero keeps protect and pause pins; one makes them data lanes.
// - Three security locks are one-time set, default unlocked, never cleared.
// - Invert bit persists, defaults zero, flips the protected range.
// - Suspend sets the erase or program suspended flag.
// - Resume or a power cycle clears both suspended flags.
// - Two-bit drive strength: 00 full, 01 75%, 10 50%, 11 25%.
// - Status protect 00: status writable whenever latch set.
// - Status protect 01: locked while protect pin low, writable when high.
// - Status protect 10: locked until power cycle, which returns them to 00.
// - Status protect 11: status word never writable.
// - In deep power-down only the release instruction is obeyed.
// - Latch set by enable; cleared by power-up, disable, writes, erases, reset.
// - Invert zero: size bits 000 protect nothing, 111 protect all.
module fswp_status_protect (
  input  wire logic                CLK_SYS,
  input  wire logic                SYS_RST,
  input  wire logic                SCLK_LINK,
  input  wire logic                LINK_CMD_VALID,
  input  wire fswp_pkg::fswp_cmd_t LINK_CMD_KIND,
  input  wire logic [23:0]         LINK_CMD_ADDR,
  input  wire logic [23:0]         LINK_CMD_DATA,
  input  wire logic                WP_PIN_N,
  input  wire logic                POWER_CYCLE,
  input  wire logic                OP_DONE,
  output logic [23:0]              LINK_STATUS,
  output logic                     BUSY,
  output logic                     OP_START,
  output fswp_pkg::fswp_cmd_t      OP_KIND,
  output logic [23:0]              OP_ADDR,
  output logic                     OP_PAUSE,
  output logic                     CMD_REFUSED,
  output logic                     QUAD_PINS,
  output logic [1:0]               DRIVE_SEL,
  output logic [2:0]               SEC_LOCK,
  output logic                     DEEP_DOWN
);
  localparam int unsigned TW_CYCLES = (`FSWP_TW_NS + `FSWP_CLK_NS - 1) / `FSWP_CLK_NS;

  // ==========================================================
  // Array protect decode
  function automatic logic prot_hit(input logic [23:0] a, input logic [4:0] bp,
                                    input logic inv);
    logic [23:0] sz;
    logic        hit;
    sz = bp[4] ? (bp[2] ? `FSWP_SZ_HALF_BLK : (`FSWP_SZ_SMALL << bp[1:0]))
               : (`FSWP_SZ_BIG << bp[2:0]);
    // none at 000, all at 111
    if (bp[2:0] == 3'h0)
      hit = 1'b0;
    else if (bp[2:0] == 3'h7)
      hit = 1'b1;
    else if (!bp[3])
      hit = (a >= (`FSWP_ARRAY_TOP - sz));
    else
      hit = (a < sz);
    return hit ^ inv;
  endfunction : prot_hit

  // ==========================================================
  // Declarations
  logic                  link_rst;
  logic                  cmd_tog_reg;
  fswp_pkg::fswp_cmd_t   kind_hold_reg;
  logic [23:0]           addr_hold_reg;
  logic [23:0]           data_hold_reg;
  logic                  pub_s;
  logic                  pub_seen_reg;
  logic                  cmd_tog_s;
  logic                  cmd_seen_reg;
  logic                  ack_s;
  logic                  wp_s;
  logic                  pub_tog_reg;
  logic [23:0]           snap_reg;
  fswp_pkg::fswp_state_t state_reg;
  fswp_pkg::fswp_state_t state_next;
  logic [23:0]           nv_reg;
  logic [23:0]           nv_next;
  logic                  wel_reg;
  logic                  wel_next;
  logic                  esus_reg;
  logic                  esus_next;
  logic                  psus_reg;
  logic                  psus_next;
  logic [15:0]           tw_reg;
  logic [15:0]           tw_next;
  logic                  pause_next;
  logic                  start_next;
  logic                  refused_next;
  fswp_pkg::fswp_cmd_t   op_kind_next;
  logic [23:0]           op_addr_next;

  // ==========================================================
  // Link domain: command capture and status view
  fswp_sync u_link_rst (.clk(SCLK_LINK), .rst(1'b0), .d(SYS_RST), .q(link_rst));
  fswp_sync u_pub (.clk(SCLK_LINK), .rst(link_rst), .d(pub_tog_reg), .q(pub_s));

  // Holding registers reload on every valid, without waiting for the toggle to cross
  always_ff @(posedge SCLK_LINK)
  begin
    if (link_rst)
    begin
      cmd_tog_reg   <= 1'b0;
      kind_hold_reg <= fswp_pkg::CMD_NONE;
      addr_hold_reg <= 24'h000000;
      data_hold_reg <= 24'h000000;
    end
    else if (LINK_CMD_VALID)
    begin
      cmd_tog_reg   <= ~cmd_tog_reg;
      kind_hold_reg <= LINK_CMD_KIND;
      addr_hold_reg <= LINK_CMD_ADDR;
      data_hold_reg <= LINK_CMD_DATA;
    end
  end

  // Snapshot is frozen while its toggle is unanswered
  always_ff @(posedge SCLK_LINK)
  begin
    if (link_rst)
    begin
      pub_seen_reg <= 1'b0;
      LINK_STATUS  <= `FSWP_STATUS_RESET;
    end
    else if (pub_s != pub_seen_reg)
    begin
      pub_seen_reg <= pub_s;
      LINK_STATUS  <= snap_reg;
    end
  end

  // ==========================================================
  // System domain crossings
  fswp_sync u_cmd (.clk(CLK_SYS), .rst(SYS_RST), .d(cmd_tog_reg), .q(cmd_tog_s));
  fswp_sync u_ack (.clk(CLK_SYS), .rst(SYS_RST), .d(pub_seen_reg), .q(ack_s));
  fswp_sync u_wp (.clk(CLK_SYS), .rst(SYS_RST), .d(WP_PIN_N), .q(wp_s));

  // ==========================================================
  // Decode
  fswp_pkg::fswp_cmd_t kind;
  wire new_cmd = cmd_tog_s ^ cmd_seen_reg;
  wire [1:0] srp = nv_reg[`FSWP_BIT_SPROT_HI:`FSWP_BIT_SPROT_LO];
  wire [4:0] bp = nv_reg[`FSWP_BIT_PSIZE_HI:`FSWP_BIT_PSIZE_LO];
  wire inv = nv_reg[`FSWP_BIT_INVERT];
  wire in_dpd = (state_reg == fswp_pkg::ST_DPD);
  wire idle = (state_reg == fswp_pkg::ST_IDLE);
  assign kind = kind_hold_reg;
  // pin acts as protect input only without quad lanes
  wire wp_eff = nv_reg[`FSWP_BIT_QUAD] | wp_s;
  wire take = new_cmd & (in_dpd ? (kind == fswp_pkg::CMD_DEEP_RELEASE)
                                : (!BUSY | (kind == fswp_pkg::CMD_SUSPEND)));
  wire srp_open = (srp == 2'b00) | ((srp == 2'b01) & wp_eff);
  // size bits move only with the whole word
  wire sr_ok = wel_reg & srp_open;
  wire [23:0] wr_val = (data_hold_reg & `FSWP_WR_MASK & ~`FSWP_LOCK_MASK)
                     | ((data_hold_reg | nv_reg) & `FSWP_LOCK_MASK);
  wire [23:0] len = (kind == fswp_pkg::CMD_PAGE_PROG)   ? `FSWP_LEN_PAGE :
                    (kind == fswp_pkg::CMD_SECT_ERASE)  ? `FSWP_LEN_SECT :
                    (kind == fswp_pkg::CMD_BLK32_ERASE) ? `FSWP_LEN_BLK32 : `FSWP_LEN_BLK64;
  // either end of the region inside the protected range blocks it
  wire range_hit = prot_hit(addr_hold_reg & ~len, bp, inv)
                 | prot_hit(addr_hold_reg | len, bp, inv);
  wire ce_ok = ((bp[2:0] == 3'h0) & !inv) | ((bp[2:0] == 3'h7) & inv);
  wire is_array = (kind == fswp_pkg::CMD_PAGE_PROG) | (kind == fswp_pkg::CMD_SECT_ERASE)
                | (kind == fswp_pkg::CMD_BLK32_ERASE) | (kind == fswp_pkg::CMD_BLK64_ERASE);
  wire is_erase_op = (OP_KIND != fswp_pkg::CMD_PAGE_PROG);
  wire [23:0] status_word = {nv_reg[23:16], esus_reg, nv_reg[14:11], psus_reg,
                             nv_reg[9:2], wel_reg, BUSY};

  // ==========================================================
  // Next-state logic
  always_comb
  begin
    state_next   = state_reg;
    nv_next      = nv_reg;
    wel_next     = wel_reg;
    esus_next    = esus_reg;
    psus_next    = psus_reg;
    tw_next      = (tw_reg != 16'h0000) ? tw_reg - 16'h0001 : 16'h0000;
    pause_next   = OP_PAUSE;
    start_next   = 1'b0;
    refused_next = 1'b0;
    op_kind_next = OP_KIND;
    op_addr_next = OP_ADDR;
    if (POWER_CYCLE)
    begin
      // lock-down ends with a power cycle
      if (srp == 2'b10)
        nv_next[`FSWP_BIT_SPROT_HI:`FSWP_BIT_SPROT_LO] = 2'b00;
      esus_next  = 1'b0;
      psus_next  = 1'b0;
      wel_next   = 1'b0;
      pause_next = 1'b0;
      tw_next    = 16'h0000;
      state_next = fswp_pkg::ST_IDLE;
    end
    else
    begin
      case (state_reg)
        fswp_pkg::ST_SRW:
          if (tw_reg == 16'h0001)
            state_next = fswp_pkg::ST_IDLE;
        fswp_pkg::ST_RUN:
          if (OP_DONE)
            state_next = fswp_pkg::ST_IDLE;
        fswp_pkg::ST_IDLE, fswp_pkg::ST_SUSP, fswp_pkg::ST_DPD:
          state_next = state_reg;
        default:
          state_next = fswp_pkg::ST_IDLE;
      endcase
      refused_next = new_cmd & !take;
      if (take)
      begin
        case (kind)
          fswp_pkg::CMD_WR_ENABLE:
            wel_next = 1'b1;
          fswp_pkg::CMD_WR_DISABLE, fswp_pkg::CMD_SOFT_RESET:
            wel_next = 1'b0;
          fswp_pkg::CMD_STATUS_WRITE:
          begin
            wel_next = 1'b0;
            if (sr_ok)
            begin
              nv_next    = wr_val;
              tw_next    = 16'(TW_CYCLES);
              state_next = fswp_pkg::ST_SRW;
            end
            else
              refused_next = 1'b1;
          end
          fswp_pkg::CMD_PAGE_PROG, fswp_pkg::CMD_SECT_ERASE, fswp_pkg::CMD_BLK32_ERASE,
          fswp_pkg::CMD_BLK64_ERASE, fswp_pkg::CMD_CHIP_ERASE:
          begin
            wel_next = 1'b0;
            if (wel_reg & idle & (is_array ? !range_hit : ce_ok))
            begin
              start_next   = 1'b1;
              op_kind_next = kind;
              op_addr_next = addr_hold_reg;
              state_next   = fswp_pkg::ST_RUN;
            end
            else
              refused_next = 1'b1;
          end
          fswp_pkg::CMD_SUSPEND:
            // flag follows the operation being paused
            if ((state_reg == fswp_pkg::ST_RUN) & !OP_DONE)
            begin
              esus_next  = is_erase_op;
              psus_next  = !is_erase_op;
              pause_next = 1'b1;
              state_next = fswp_pkg::ST_SUSP;
            end
          fswp_pkg::CMD_RESUME:
            if (state_reg == fswp_pkg::ST_SUSP)
            begin
              esus_next  = 1'b0;
              psus_next  = 1'b0;
              pause_next = 1'b0;
              state_next = fswp_pkg::ST_RUN;
            end
          fswp_pkg::CMD_DEEP_DOWN:
            if (idle)
              state_next = fswp_pkg::ST_DPD;
          fswp_pkg::CMD_DEEP_RELEASE:
            if (in_dpd)
              state_next = fswp_pkg::ST_IDLE;
          default:
            state_next = state_next;
        endcase
      end
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
    begin
      state_reg    <= fswp_pkg::ST_IDLE;
      nv_reg       <= `FSWP_STATUS_RESET;
      wel_reg      <= 1'b0;
      esus_reg     <= 1'b0;
      psus_reg     <= 1'b0;
      tw_reg       <= 16'h0000;
      cmd_seen_reg <= 1'b0;
    end
    else
    begin
      state_reg    <= state_next;
      nv_reg       <= nv_next;
      wel_reg      <= wel_next;
      esus_reg     <= esus_next;
      psus_reg     <= psus_next;
      tw_reg       <= tw_next;
      cmd_seen_reg <= cmd_tog_s;
    end
  end

  // Outputs, all from flops
  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
    begin
      BUSY        <= 1'b0;
      OP_START    <= 1'b0;
      OP_KIND     <= fswp_pkg::CMD_NONE;
      OP_ADDR     <= 24'h000000;
      OP_PAUSE    <= 1'b0;
      CMD_REFUSED <= 1'b0;
      QUAD_PINS   <= 1'b0;
      DRIVE_SEL   <= 2'h0;
      SEC_LOCK    <= 3'h0;
      DEEP_DOWN   <= 1'b0;
    end
    else
    begin
      BUSY        <= (state_next == fswp_pkg::ST_SRW) | (state_next == fswp_pkg::ST_RUN);
      OP_START    <= start_next;
      OP_KIND     <= op_kind_next;
      OP_ADDR     <= op_addr_next;
      OP_PAUSE    <= pause_next;
      CMD_REFUSED <= refused_next;
      QUAD_PINS   <= nv_next[`FSWP_BIT_QUAD];
      DRIVE_SEL   <= nv_next[`FSWP_BIT_DRV_HI:`FSWP_BIT_DRV_LO];
      SEC_LOCK    <= nv_next[`FSWP_BIT_LOCK_HI:`FSWP_BIT_LOCK_LO];
      DEEP_DOWN   <= (state_next == fswp_pkg::ST_DPD);
    end
  end

  // Status snapshot publishes only after the previous one was taken
  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
    begin
      pub_tog_reg <= 1'b0;
      snap_reg    <= `FSWP_STATUS_RESET;
    end
    else if ((pub_tog_reg == ack_s) & (snap_reg != status_word))
    begin
      pub_tog_reg <= ~pub_tog_reg;
      snap_reg    <= status_word;
    end
  end

  // ==========================================================
  // Checks
  a_busy_status_write: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    $rose(state_reg == fswp_pkg::ST_SRW) |-> BUSY [*8])
    else $error("busy dropped during status write");
  a_latch_gates_write: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (take & !wel_reg & (is_array | (kind == fswp_pkg::CMD_CHIP_ERASE))) |=> !OP_START)
    else $error("operation started without latch");
  a_range_blocks_op: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (take & is_array & range_hit) |=> !OP_START && CMD_REFUSED)
    else $error("protected region not blocked");
  a_hw_protect_hold: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (take & (kind == fswp_pkg::CMD_STATUS_WRITE) & (srp == 2'b01) & !wp_eff)
      |=> nv_reg == $past(nv_reg) && !wel_reg)
    else $error("status written while pin protected");
  a_chip_erase_gate: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (OP_START & (OP_KIND == fswp_pkg::CMD_CHIP_ERASE)) |-> $past(ce_ok))
    else $error("chip erase with protected range");
  a_lock_never_clears: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    ($past(SEC_LOCK) & ~SEC_LOCK) == 3'h0)
    else $error("security lock cleared");
  a_suspend_sets_flag: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (take & (kind == fswp_pkg::CMD_SUSPEND) & (state_reg == fswp_pkg::ST_RUN) & !OP_DONE)
      |=> (esus_reg ^ psus_reg) && OP_PAUSE && !BUSY)
    else $error("suspend flag not set");
  a_resume_clears: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (take & (kind == fswp_pkg::CMD_RESUME)) |=> !esus_reg && !psus_reg)
    else $error("suspend flags survive resume");
  a_lockdown_release: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (POWER_CYCLE & (srp == 2'b10)) |=> srp == 2'b00 && !wel_reg)
    else $error("lock-down not released");
  a_otp_status_fixed: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (srp == 2'b11) |=> nv_reg == $past(nv_reg))
    else $error("one-time status word changed");
  a_deep_down_ignore: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (in_dpd & new_cmd & (kind != fswp_pkg::CMD_DEEP_RELEASE) & !POWER_CYCLE)
      |=> DEEP_DOWN && wel_reg == $past(wel_reg))
    else $error("instruction obeyed in deep power-down");
  a_reserved_zero: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (status_word & ~(`FSWP_WR_MASK | 24'h008403)) == 24'h000000)
    else $error("reserved status bit set");
  c_status_write: cover property (@(posedge CLK_SYS) disable iff (SYS_RST)
    state_reg == fswp_pkg::ST_SRW);
  c_suspend_resume: cover property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (state_reg == fswp_pkg::ST_SUSP) ##[1:200] (state_reg == fswp_pkg::ST_RUN));
  c_chip_erase: cover property (@(posedge CLK_SYS) disable iff (SYS_RST)
    OP_START & (OP_KIND == fswp_pkg::CMD_CHIP_ERASE));
endmodule : fswp_status_protect

// File: common/fswp_map.svh
// Bit positions, masks, reset values and timing for the status and protect block
`ifndef FSWP_MAP_SVH
`define FSWP_MAP_SVH
// ==========================================================
// Status word field positions
`define FSWP_BIT_BUSY     0
`define FSWP_BIT_WR_LATCH 1
`define FSWP_BIT_PSIZE_LO 2
`define FSWP_BIT_PSIZE_HI 6
`define FSWP_BIT_SPROT_LO 7
`define FSWP_BIT_SPROT_HI 8
`define FSWP_BIT_QUAD     9
`define FSWP_BIT_PSUSP    10
`define FSWP_BIT_LOCK_LO  11
`define FSWP_BIT_LOCK_HI  13
`define FSWP_BIT_INVERT   14
`define FSWP_BIT_ESUSP    15
`define FSWP_BIT_DRV_LO   21
`define FSWP_BIT_DRV_HI   22
// ==========================================================
// Masks and reset values
`define FSWP_WR_MASK      24'h607BFC
`define FSWP_LOCK_MASK    24'h003800
`define FSWP_STATUS_RESET 24'h000000
// ==========================================================
// Array geometry
`define FSWP_ARRAY_TOP    24'h800000
`define FSWP_SZ_SMALL     24'h000800
`define FSWP_SZ_HALF_BLK  24'h008000
`define FSWP_SZ_BIG       24'h010000
`define FSWP_LEN_PAGE     24'h0000FF
`define FSWP_LEN_SECT     24'h000FFF
`define FSWP_LEN_BLK32    24'h007FFF
`define FSWP_LEN_BLK64    24'h00FFFF
// ==========================================================
// Timing
`define FSWP_TW_NS        1000
`define FSWP_CLK_NS       8
`endif

// File: common/fswp_pkg.sv
// Types shared by the status and protect block
package fswp_pkg;
  // ==========================================================
  // Decoded instruction kinds
  typedef enum logic [3:0] {
    CMD_NONE         = 4'h0,
    CMD_WR_ENABLE    = 4'h1,
    CMD_WR_DISABLE   = 4'h2,
    CMD_STATUS_WRITE = 4'h3,
    CMD_PAGE_PROG    = 4'h4,
    CMD_SECT_ERASE   = 4'h5,
    CMD_BLK32_ERASE  = 4'h6,
    CMD_BLK64_ERASE  = 4'h7,
    CMD_CHIP_ERASE   = 4'h8,
    CMD_SUSPEND      = 4'h9,
    CMD_RESUME       = 4'hA,
    CMD_DEEP_DOWN    = 4'hB,
    CMD_DEEP_RELEASE = 4'hC,
    CMD_SOFT_RESET   = 4'hD
  } fswp_cmd_t;
  // ==========================================================
  // Control states
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_SRW  = 5'b00010,
    ST_RUN  = 5'b00100,
    ST_SUSP = 5'b01000,
    ST_DPD  = 5'b10000
  } fswp_state_t;
endpackage : fswp_pkg

// File: design/fswp_sync.sv
// Two-flop level synchroniser
`timescale 1ns/1ns
module fswp_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_reg;
  // ==========================================================
  // First stage feeds only the second
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta_reg <= '0;
      q        <= '0;
    end
    else
    begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule : fswp_sync

// File: verif/fswp_host_model.sv
// Host side model that issues decoded instructions on the link clock
`timescale 1ns/1ns
module fswp_host_model (
  output logic                SCLK_LINK,
  output logic                LINK_CMD_VALID,
  output fswp_pkg::fswp_cmd_t LINK_CMD_KIND,
  output logic [23:0]         LINK_CMD_ADDR,
  output logic [23:0]         LINK_CMD_DATA
);
  // ==========================================================
  // Link clock stands still between transfers
  initial
  begin
    SCLK_LINK = 1'b0;
    LINK_CMD_VALID = 1'b0;
    LINK_CMD_KIND = fswp_pkg::CMD_NONE;
    LINK_CMD_ADDR = 24'h000000;
    LINK_CMD_DATA = 24'hFFFFFF;
  end
  // Rising edge kept 1 ns after a system clock rising edge; the 64 ns period holds that phase fixed
  task automatic run(input int n);
    repeat (n)
    begin
      #29 SCLK_LINK = 1'b1;
      #35 SCLK_LINK = 1'b0;
    end
  endtask : run
  // ==========================================================
  // One instruction, then an idle cycle for spacing
  // no four-lane instruction issued
  task automatic send(input fswp_pkg::fswp_cmd_t k, input logic [23:0] a, input logic [23:0] d);
    LINK_CMD_VALID = 1'b1;
    LINK_CMD_KIND = k;
    LINK_CMD_ADDR = a;
    LINK_CMD_DATA = d;
    run(1);
    LINK_CMD_VALID = 1'b0;
    LINK_CMD_KIND = fswp_pkg::CMD_NONE;
    LINK_CMD_ADDR = ~a;
    LINK_CMD_DATA = ~d;
    run(1);
  endtask : send
endmodule : fswp_host_model

// File: verif/test_fswp_status_protect.sv
// Self-checking bench for the status and protect block
`timescale 1ns/1ns
module test_fswp_status_protect;
  // ==========================================================
  // Signals
  logic                CLK_SYS;
  logic                SYS_RST;
  logic                SCLK_LINK;
  logic                LINK_CMD_VALID;
  fswp_pkg::fswp_cmd_t LINK_CMD_KIND;
  logic [23:0]         LINK_CMD_ADDR;
  logic [23:0]         LINK_CMD_DATA;
  logic                WP_PIN_N;
  logic                POWER_CYCLE;
  logic                OP_DONE;
  logic [23:0]         LINK_STATUS;
  logic                BUSY;
  logic                OP_START;
  fswp_pkg::fswp_cmd_t OP_KIND;
  logic [23:0]         OP_ADDR;
  logic                OP_PAUSE;
  logic                CMD_REFUSED;
  logic                QUAD_PINS;
  logic [1:0]          DRIVE_SEL;
  logic [2:0]          SEC_LOCK;
  logic                DEEP_DOWN;
  int                  miscompares;
  int                  compares;
  int                  refused_n;
  int                  started_n;
  fswp_status_protect fswp_status_protect_i (.CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST),
    .SCLK_LINK(SCLK_LINK), .LINK_CMD_VALID(LINK_CMD_VALID), .LINK_CMD_KIND(LINK_CMD_KIND),
    .LINK_CMD_ADDR(LINK_CMD_ADDR), .LINK_CMD_DATA(LINK_CMD_DATA), .WP_PIN_N(WP_PIN_N),
    .POWER_CYCLE(POWER_CYCLE), .OP_DONE(OP_DONE), .LINK_STATUS(LINK_STATUS), .BUSY(BUSY),
    .OP_START(OP_START), .OP_KIND(OP_KIND), .OP_ADDR(OP_ADDR), .OP_PAUSE(OP_PAUSE),
    .CMD_REFUSED(CMD_REFUSED), .QUAD_PINS(QUAD_PINS), .DRIVE_SEL(DRIVE_SEL),
    .SEC_LOCK(SEC_LOCK), .DEEP_DOWN(DEEP_DOWN));
  fswp_host_model fswp_host_model_i (.SCLK_LINK(SCLK_LINK), .LINK_CMD_VALID(LINK_CMD_VALID),
    .LINK_CMD_KIND(LINK_CMD_KIND), .LINK_CMD_ADDR(LINK_CMD_ADDR),
    .LINK_CMD_DATA(LINK_CMD_DATA));
  // ==========================================================
  // Clock, pulse counters, watchdog
  initial
  begin
    CLK_SYS = 1'b0;
    forever #4 CLK_SYS = ~CLK_SYS;
  end
  // Pulses last one cycle, so they are counted rather than polled
  always @(posedge CLK_SYS)
  begin
    if (CMD_REFUSED === 1'b1)
      refused_n++;
    if (OP_START === 1'b1)
      started_n++;
  end
  initial
  begin
    #200000;
    miscompares++;
    results();
  end
  // ==========================================================
  // Tasks
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic cmd(input fswp_pkg::fswp_cmd_t k, input logic [23:0] a, input logic [23:0] d,
                     input int r, input int s);
    int r0;
    int s0;
    r0 = refused_n;
    s0 = started_n;
    fswp_host_model_i.send(k, a, d);
    chk("refused", 24'(r), 24'(refused_n - r0));
    chk("started", 24'(s), 24'(started_n - s0));
  endtask : cmd
  task automatic st(input logic [23:0] exp);
    fswp_host_model_i.run(6);
    chk("status", exp, LINK_STATUS);
  endtask : st
  task automatic idle();
    int i;
    for (i = 0; i < 300 && BUSY !== 1'b0; i++)
      @(negedge CLK_SYS);
    chk("busy", 24'h000000, {23'h0, BUSY});
  endtask : idle
  task automatic pulse(input logic pc);
    @(negedge CLK_SYS);
    if (pc)
      POWER_CYCLE = 1'b1;
    else
      OP_DONE = 1'b1;
    @(negedge CLK_SYS);
    POWER_CYCLE = 1'b0;
    OP_DONE = 1'b0;
  endtask : pulse
  task automatic results();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : results
  // ==========================================================
  // Tests
  initial
  begin
    SYS_RST = 1'b1;
    WP_PIN_N = 1'b0;
    POWER_CYCLE = 1'b0;
    OP_DONE = 1'b0;
    fork
      fswp_host_model_i.run(3);
    join_none
    repeat (21) @(negedge CLK_SYS);
    SYS_RST = 1'b0;
    repeat (4) @(negedge CLK_SYS);
    fswp_host_model_i.run(3);
    st(24'h000000);
    chk("pins", 24'h000000, {16'h0, DRIVE_SEL, SEC_LOCK, QUAD_PINS, DEEP_DOWN, BUSY});
    cmd(fswp_pkg::CMD_STATUS_WRITE, 24'h0, 24'h000004, 1, 0);
    cmd(fswp_pkg::CMD_WR_ENABLE, 24'h0, 24'h0, 0, 0);
    st(24'h000002);
    cmd(fswp_pkg::CMD_STATUS_WRITE, 24'h0, 24'hFFFE7F, 0, 0);
    chk("busy", 24'h000001, {23'h0, BUSY});
    idle();
    st(24'h607A7C);
    chk("pins", 24'h00003F, {18'h0, DRIVE_SEL, SEC_LOCK, QUAD_PINS});
    cmd(fswp_pkg::CMD_WR_ENABLE, 24'h0, 24'h0, 0, 0);
    cmd(fswp_pkg::CMD_CHIP_ERASE, 24'h0, 24'h0, 0, 1);
    chk("kind", 24'h000008, {20'h0, OP_KIND});
    pulse(1'b0);
    idle();
    cmd(fswp_pkg::CMD_WR_ENABLE, 24'h0, 24'h0, 0, 0);
    cmd(fswp_pkg::CMD_STATUS_WRITE, 24'h0, 24'h000000, 0, 0);
    idle();
    st(24'h003800);
    cmd(fswp_pkg::CMD_WR_ENABLE, 24'h0, 24'h0, 0, 0);
    cmd(fswp_pkg::CMD_SECT_ERASE, 24'h001000, 24'h0, 0, 1);
    chk("addr", 24'h001000, OP_ADDR);
    cmd(fswp_pkg::CMD_SUSPEND, 24'h0, 24'h0, 0, 0);
    chk("pause", 24'h000001, {23'h0, OP_PAUSE});
    st(24'h00B800);
    cmd(fswp_pkg::CMD_RESUME, 24'h0, 24'h0, 0, 0);
    st(24'h003801);
    pulse(1'b0);
    idle();
    cmd(fswp_pkg::CMD_WR_ENABLE, 24'h0, 24'h0, 0, 0);
    cmd(fswp_pkg::CMD_PAGE_PROG, 24'h000000, 24'h0, 0, 1);
    cmd(fswp_pkg::CMD_SUSPEND, 24'h0, 24'h0, 0, 0);
    st(24'h003C00);
    pulse(1'b1);
    st(24'h003800);
    cmd(fswp_pkg::CMD_WR_ENABLE, 24'h0, 24'h0, 0, 0);
    cmd(fswp_pkg::CMD_STATUS_WRITE, 24'h0, 24'h00001C, 0, 0);
    idle();
    cmd(fswp_pkg::CMD_WR_ENABLE, 24'h0, 24'h0, 0, 0);
    cmd(fswp_pkg::CMD_PAGE_PROG, 24'h000100, 24'h0, 1, 0);
    cmd(fswp_pkg::CMD_WR_ENABLE, 24'h0, 24'h0, 0, 0);
    cmd(fswp_pkg::CMD_CHIP_ERASE, 24'h0, 24'h0, 1, 0);
    st(24'h00381C);
    cmd(fswp_pkg::CMD_WR_ENABLE, 24'h0, 24'h0, 0, 0);
    cmd(fswp_pkg::CMD_WR_DISABLE, 24'h0, 24'h0, 0, 0);
    cmd(fswp_pkg::CMD_STATUS_WRITE, 24'h0, 24'h0, 1, 0);
    cmd(fswp_pkg::CMD_DEEP_DOWN, 24'h0, 24'h0, 0, 0);
    chk("deep", 24'h000001, {23'h0, DEEP_DOWN});
    cmd(fswp_pkg::CMD_WR_ENABLE, 24'h0, 24'h0, 1, 0);
    cmd(fswp_pkg::CMD_DEEP_RELEASE, 24'h0, 24'h0, 0, 0);
    chk("deep", 24'h000000, {23'h0, DEEP_DOWN});
    cmd(fswp_pkg::CMD_WR_ENABLE, 24'h0, 24'h0, 0, 0);
    cmd(fswp_pkg::CMD_STATUS_WRITE, 24'h0, 24'h000080, 0, 0);
    idle();
    cmd(fswp_pkg::CMD_WR_ENABLE, 24'h0, 24'h0, 0, 0);
    cmd(fswp_pkg::CMD_STATUS_WRITE, 24'h0, 24'h00009C, 1, 0);
    st(24'h003880);
    @(negedge CLK_SYS);
    WP_PIN_N = 1'b1;
    cmd(fswp_pkg::CMD_WR_ENABLE, 24'h0, 24'h0, 0, 0);
    cmd(fswp_pkg::CMD_STATUS_WRITE, 24'h0, 24'h000100, 0, 0);
    idle();
    st(24'h003900);
    cmd(fswp_pkg::CMD_WR_ENABLE, 24'h0, 24'h0, 0, 0);
    cmd(fswp_pkg::CMD_STATUS_WRITE, 24'h0, 24'h000000, 1, 0);
    pulse(1'b1);
    st(24'h003800);
    cmd(fswp_pkg::CMD_WR_ENABLE, 24'h0, 24'h0, 0, 0);
    cmd(fswp_pkg::CMD_STATUS_WRITE, 24'h0, 24'h000180, 0, 0);
    idle();
    cmd(fswp_pkg::CMD_WR_ENABLE, 24'h0, 24'h0, 0, 0);
    cmd(fswp_pkg::CMD_STATUS_WRITE, 24'h0, 24'h000000, 1, 0);
    st(24'h003980);
    results();
  end
endmodule : test_fswp_status_protect
